// ==== common/ssbc_params.svh ====
// Constants for the stack bus controller: transfer codes, alias windows, codes.
// Assumes AHB encodings and a 40 MHz tile oscillator on clk_sys.
`ifndef SSBC_PARAMS_SVH
`define SSBC_PARAMS_SVH
`define SSBC_TRANS_IDLE    2'h0
`define SSBC_TRANS_NONSEQ  2'h2
`define SSBC_RESP_OKAY     2'h0
`define SSBC_RESP_ERROR    2'h1
`define SSBC_ALIAS_FIRST   4'h8
`define SSBC_ALIAS_LAST    4'hb
`define SSBC_ADDR_TOP      31
`define SSBC_ADDR_NIB      28
`define SSBC_POS_BASE      4'he
`define SSBC_PROC_LINE     3
`define SSBC_CLK_HALF      1
`define SSBC_TILE_MASTERS  1
`endif

// ==== common/ssbc_pkg.sv ====
// Types shared by the stack bus controller files.
// Assumes the parameter header is compiled alongside.
package ssbc_pkg;
    // Address phase as seen on the shared system bus.
    typedef struct packed {
        logic [31:0] addr;
        logic [1:0]  trans;
        logic        ready;
    } ssbc_ahb_type;
    // Drive onto the shared ready and response lines.
    typedef struct packed {
        logic       ready;
        logic [1:0] resp;
        logic       oe;
    } ssbc_resp_type;
    typedef enum logic [1:0] {
        ssbc_ds_idle,
        ssbc_ds_okay,
        ssbc_ds_first,
        ssbc_ds_second
    } ssbc_ds_state_type;
endpackage

// ==== verilog/ssbc_reset_sync.sv ====
// Two cascaded flops that make the synchronised system reset.
// Assumes clr_n combines the wired request with the local power-on reset.
`timescale 1ns/1ps
`default_nettype none
module ssbc_reset_sync (
    input  wire logic clk_sys,
    input  wire logic clr_n,
    input  wire logic bus_en,
    output var  logic rst_n_q
);
    logic stage_q;
    logic stage_d;
    logic rst_n_d;

    // A one walks in on bus clock edges; clearing is immediate.
    always_comb begin
        stage_d = bus_en ? 1'b1 : stage_q;
        rst_n_d = bus_en ? stage_q : rst_n_q;
    end

    // Both stages clear at once while the request is low.
    always_ff @(posedge clk_sys or negedge clr_n) begin
        if (!clr_n) begin
            stage_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            stage_q <= stage_d;
            rst_n_q <= rst_n_d;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/ssbc_default_slave.sv ====
// Default slave: ERROR for unused addresses, OKAY for idle transfers.
// Assumes bus_en marks the rising edge of the shared bus clock.
`include "ssbc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ssbc_default_slave (
    input  wire logic                  clk_sys,
    input  wire logic                  reset_n,
    input  wire logic                  bus_en,
    input  wire logic                  sel,
    input  wire ssbc_pkg::ssbc_ahb_type ahb,
    output var  ssbc_pkg::ssbc_resp_type rsp_q,
    output var  ssbc_pkg::ssbc_ds_state_type state_q
);
    ssbc_pkg::ssbc_ds_state_type state_d;
    ssbc_pkg::ssbc_resp_type     rsp_d;

    // A new selection is taken only when the bus shows ready.
    always_comb begin
        state_d = state_q;
        if (bus_en) begin
            if (state_q == ssbc_pkg::ssbc_ds_first) begin
                state_d = ssbc_pkg::ssbc_ds_second;
            end else if (sel && ahb.ready && ahb.trans[1]) begin
                state_d = ssbc_pkg::ssbc_ds_first;
            end else if (sel && ahb.ready) begin
                state_d = ssbc_pkg::ssbc_ds_okay;
            end else if (ahb.ready) begin
                state_d = ssbc_pkg::ssbc_ds_idle;
            end
        end
        rsp_d.oe    = state_d != ssbc_pkg::ssbc_ds_idle;
        rsp_d.ready = state_d != ssbc_pkg::ssbc_ds_first;
        rsp_d.resp  = (state_d == ssbc_pkg::ssbc_ds_okay) ? `SSBC_RESP_OKAY
                                                           : `SSBC_RESP_ERROR;
    end

    // The drive is registered so the shared lines never glitch.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ssbc_pkg::ssbc_ds_idle;
            rsp_q   <= '0;
        end else begin
            state_q <= state_d;
            rsp_q   <= rsp_d;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/ssbc_stack_ctrl.sv ====
// Bus management for a processor, interface module and tile stack.
// Assumes clk_sys is a tile oscillator and every bus pin is on its bus clock.
`include "ssbc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ssbc_stack_ctrl #(
    parameter int TILE_MASTERS  = `SSBC_TILE_MASTERS,
    parameter int MODULES_BELOW = 0,
    parameter int CLK_HALF      = `SSBC_CLK_HALF,
    parameter bit DUMMY_MASTER  = 1'b1
) (
    input  wire logic                    clk_sys,
    input  wire logic                    reset_n,
    input  wire logic                    tile_reset_req,
    input  wire logic                    wired_reset_request_n_i,
    output logic                         wired_reset_request_n_o,
    output logic                         wired_reset_request_n_oe,
    output var  logic                    system_reset_n,
    output var  logic                    backplane_clock_three,
    output logic [3:0]                   stack_position_code,
    input  wire ssbc_pkg::ssbc_ahb_type  ahb,
    input  wire logic                    tile_slave_hit,
    output var  ssbc_pkg::ssbc_resp_type bus_resp,
    input  wire logic [3:0]              bus_request,
    input  wire logic [3:0]              bus_lock,
    output var  logic [3:0]              bus_grant,
    output logic [2:0]                   tile_master_oe,
    output logic [1:0]                   dummy_trans,
    output var  logic                    dummy_grant
);
    ////////////////////////////////////////////////////////////////////////
    // Bus clock: a toggle divider; bus_en marks each rising edge.
    logic [7:0] div_q;
    logic [7:0] div_d;
    logic       clk_d;
    logic       tick;
    logic       bus_en;

    // One system clock only, so bus logic steps on bus_en rather than on
    // the divided clock; the pin clock rises on the clk_sys edge that bus_en enables.
    always_comb begin
        tick   = div_q == 8'(CLK_HALF - 1);
        div_d  = tick ? 8'h00 : div_q + 8'h01;
        clk_d  = tick ? !backplane_clock_three : backplane_clock_three;
        bus_en = tick && !backplane_clock_three;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            div_q                 <= 8'h00;
            backplane_clock_three <= 1'b0;
        end else begin
            div_q                 <= div_d;
            backplane_clock_three <= clk_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset: local sources only ever pull the wired line low.
    logic rst_clr_n;

    assign wired_reset_request_n_o  = 1'b0;
    assign wired_reset_request_n_oe = tile_reset_req;
    // The probe and processor pull the same line, so they clear us too.
    assign rst_clr_n = reset_n && wired_reset_request_n_i;

    ssbc_reset_sync u_reset_sync (
        .clk_sys (clk_sys),
        .clr_n   (rst_clr_n),
        .bus_en  (bus_en),
        .rst_n_q (system_reset_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // Position code: fixed at build time, rotated right per module below.
    localparam logic [7:0] POS_PAIR = {`SSBC_POS_BASE, `SSBC_POS_BASE};
    assign stack_position_code = 4'(POS_PAIR >> (MODULES_BELOW % 4));

    ////////////////////////////////////////////////////////////////////////
    // Decode and response: alias windows belong to the processors.
    logic [3:0]                  nib;
    logic                        in_alias;
    logic                        ds_sel;
    logic                        presel_q;
    logic                        presel_d;
    ssbc_pkg::ssbc_resp_type     ds_rsp;
    ssbc_pkg::ssbc_ds_state_type ds_state;

    assign nib      = ahb.addr[`SSBC_ADDR_TOP:`SSBC_ADDR_NIB];
    assign in_alias = nib >= `SSBC_ALIAS_FIRST && nib <= `SSBC_ALIAS_LAST;
    assign ds_sel   = !in_alias && !tile_slave_hit;

    ssbc_default_slave u_default_slave (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .bus_en  (bus_en),
        .sel     (ds_sel),
        .ahb     (ahb),
        .rsp_q   (ds_rsp),
        .state_q (ds_state)
    );

    // The pre-selected drive ends once the first transfer is taken;
    // without it the pulled-down ready line would hold off every master.
    always_comb begin
        presel_d = presel_q;
        if (!system_reset_n) begin
            presel_d = 1'b1;
        end else if (bus_en && ahb.ready && ahb.trans[1]) begin
            presel_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            presel_q <= 1'b1;
        end else begin
            presel_q <= presel_d;
        end
    end

    // Pre-selection shows an OKAY, ready drive ahead of the default slave.
    always_comb begin
        bus_resp = ds_rsp;
        if (presel_q) begin
            bus_resp.oe    = 1'b1;
            bus_resp.ready = 1'b1;
            bus_resp.resp  = `SSBC_RESP_OKAY;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Arbiter: processor on line three, tile masters on lines 0 upward.
    logic [1:0] owner_q;
    logic [1:0] owner_d;
    logic       dummy_d;
    logic [3:0] grant_d;
    logic       hold;

    // Re-arbitrate only on a bus edge with ready high; a locked owner
    // still requesting keeps the bus. Processor has highest priority.
    always_comb begin
        owner_d = owner_q;
        dummy_d = dummy_grant;
        hold    = bus_lock[owner_q] && bus_request[owner_q] && !dummy_grant;
        if (!system_reset_n) begin
            dummy_d = DUMMY_MASTER;
            owner_d = 2'(`SSBC_PROC_LINE);
        end else if (bus_en && ahb.ready && !hold) begin
            dummy_d = 1'b0;
            owner_d = 2'(`SSBC_PROC_LINE);
            if (!bus_request[`SSBC_PROC_LINE]) begin
                for (int i = TILE_MASTERS - 1; i >= 0; i--) begin
                    if (bus_request[i]) begin
                        owner_d = 2'(i);
                    end
                end
            end
        end
        grant_d = '0;
        if (TILE_MASTERS == 0) begin
            grant_d[`SSBC_PROC_LINE] = 1'b1;
        end else if (!dummy_d) begin
            grant_d[owner_d] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            owner_q     <= 2'(`SSBC_PROC_LINE);
            dummy_grant <= 1'b1;
            bus_grant   <= '0;
        end else begin
            owner_q     <= owner_d;
            dummy_grant <= dummy_d;
            bus_grant   <= grant_d;
        end
    end

    // Tile masters drive only while they hold the grant; dummy_trans shows IDLE at all times.
    assign tile_master_oe = bus_grant[2:0];
    assign dummy_trans    = `SSBC_TRANS_IDLE;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_release_on_edge: assert property ($rose(system_reset_n) |-> $past(bus_en))
        else $error("system reset released off a bus clock edge");
    a_clear_follows: assert property (!rst_clr_n |-> !system_reset_n)
        else $error("system reset not low while request low");
    a_two_stage: assert property (
        $rose(system_reset_n) |-> $past(system_reset_n, 1) == 1'b0 && u_reset_sync.stage_q)
        else $error("reset did not pass both stages");
    a_open_drain: assert property (
        tile_reset_req |-> wired_reset_request_n_oe && !wired_reset_request_n_o)
        else $error("reset request not pulled low");
    // Rotating right moves the single zero down from bit 0 to bit 3, then 2, then 1.
    a_position_code: assert property (
        stack_position_code[(4 - MODULES_BELOW % 4) % 4] == 1'b0
        && $countones(stack_position_code) == 3)
        else $error("position code zero bit misplaced");
    a_alias_silent: assert property (
        bus_en && ahb.ready && ahb.trans[1] && in_alias && !presel_q
        |=> !bus_resp.oe)
        else $error("drive onto an alias window access");
    // The first state lasts one bus clock, so the ready half follows within a few cycles.
    a_error_pair: assert property (
        ds_state == ssbc_pkg::ssbc_ds_first |-> bus_resp.resp == `SSBC_RESP_ERROR
        && !bus_resp.ready ##[1:8] (bus_resp.ready
        && bus_resp.resp == `SSBC_RESP_ERROR))
        else $error("error response not two cycles");
    a_preselect_drive: assert property (
        !system_reset_n |=> bus_resp.oe && bus_resp.ready)
        else $error("no ready drive during reset");
    a_dummy_in_reset: assert property (
        !system_reset_n && DUMMY_MASTER |=> dummy_grant && bus_grant[2:0] == 3'h0)
        else $error("dummy master not granted in reset");
    a_sole_grant: assert property (
        TILE_MASTERS == 0 && system_reset_n |=> bus_grant == 4'h8)
        else $error("sole master grant not held");
    a_lock_hold: assert property (
        bus_en && system_reset_n && hold && $stable(bus_grant) |=> $stable(bus_grant))
        else $error("locked grant moved");
    a_grant_onehot: assert property ($onehot0({bus_grant, dummy_grant}))
        else $error("two masters granted");

    c_boot_exit: cover property ($rose(system_reset_n) ##[1:40] !presel_q);
    c_error_resp: cover property (ds_state == ssbc_pkg::ssbc_ds_second);
    c_tile_grant: cover property (bus_grant[0] ##1 bus_grant[3]);
endmodule
`default_nettype wire

// ==== tb/ssbc_proc_model.sv ====
// Processor module model: bus master, alias window slave, reset line holder.
// Assumes the controller drives the bus clock and the shared ready and response drive.
`include "ssbc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ssbc_proc_model (
    input  wire logic                    clk_sys,
    input  wire logic                    bus_clk,
    input  wire logic                    all_configured,
    input  wire logic                    probe_reset,
    input  wire logic                    tile_oe,
    input  wire logic                    slave_hit,
    input  wire ssbc_pkg::ssbc_resp_type rsp,
    input  wire logic [31:0]             next_addr,
    input  wire logic [1:0]              next_trans,
    output var  ssbc_pkg::ssbc_ahb_type  ahb,
    output wire logic                    line_n
);
    logic        prev_clk = 1'h0;
    logic        other_dp = 1'h0;
    logic        rdy_s;
    logic [31:0] a_q = 32'h0;
    logic [1:0]  t_q = `SSBC_TRANS_IDLE;
    ////////////////////////////////////////
    // Pulled up; the processor holds it low until all devices are configured.
    assign line_n = !(tile_oe || !all_configured || probe_reset);
    // Ready is pulled down when no slave drives it.
    assign ahb = '{addr: a_q, trans: t_q, ready: rsp.oe ? rsp.ready : other_dp};
    ////////////////////////////////////////
    // A new address phase starts only after a bus clock edge that saw ready high.
    always @(posedge clk_sys) begin
        rdy_s = ahb.ready;
        #1;
        if (bus_clk && !prev_clk && rdy_s) begin
            // Stands in for every processor module answering its own alias window, and for the tile slave on a hit.
            other_dp = (a_q[31:28] >= 4'h8 && a_q[31:28] <= 4'hb) || slave_hit;
            a_q = next_addr;
            t_q = next_trans;
        end
        prev_clk = bus_clk;
    end
endmodule
`default_nettype wire

// ==== tb/test_standalone_stack_bus_controller.sv ====
// Testbench for the stack bus controller, one task per scenario.
// Assumes the processor model answers alias windows and holds the reset line.
`include "ssbc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module test_standalone_stack_bus_controller;
    logic                    clk_sys;
    logic                    reset_n;
    logic                    tile_req;
    logic                    probe;
    logic                    cfg;
    logic                    hit;
    logic [31:0]             nxt_addr;
    logic [1:0]              nxt_trans;
    logic [3:0]              bus_request;
    logic [3:0]              bus_lock;
    logic                    line_n;
    logic                    rq_o;
    logic                    rq_oe;
    logic                    sys_rst_n;
    logic                    bclk;
    logic [3:0]              pos;
    ssbc_pkg::ssbc_ahb_type  ahb;
    ssbc_pkg::ssbc_resp_type bus_resp;
    logic [3:0]              bus_grant;
    logic [2:0]              tm_oe;
    logic [1:0]              dtrans;
    logic                    dgrant;
    int                      err_count;
    int                      n_checks;
    int                      cyc = 0;
    ////////////////////////////////////////
    ssbc_stack_ctrl dut_u (
        .clk_sys(clk_sys), .reset_n(reset_n), .tile_reset_req(tile_req),
        .wired_reset_request_n_i(line_n), .wired_reset_request_n_o(rq_o),
        .wired_reset_request_n_oe(rq_oe), .system_reset_n(sys_rst_n),
        .backplane_clock_three(bclk), .stack_position_code(pos), .ahb(ahb),
        .tile_slave_hit(hit), .bus_resp(bus_resp), .bus_request(bus_request),
        .bus_lock(bus_lock), .bus_grant(bus_grant), .tile_master_oe(tm_oe),
        .dummy_trans(dtrans), .dummy_grant(dgrant));
    ssbc_proc_model proc_u (
        .clk_sys(clk_sys), .bus_clk(bclk), .all_configured(cfg), .probe_reset(probe),
        .tile_oe(rq_oe), .slave_hit(hit), .rsp(bus_resp), .next_addr(nxt_addr),
        .next_trans(nxt_trans), .ahb(ahb), .line_n(line_n));
    ////////////////////////////////////////
    // A 40 MHz clock, and a ceiling well above the run's length.
    initial begin
        clk_sys = 1'h0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end
    task automatic chk1(input string name, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic chk4(input string name, input logic [3:0] exp, input logic [3:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Inputs move 2 ns after an edge, so outputs are settled when sampled.
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic wait_resp(input logic [3:0] want, input int lim);
        for (int i = 0; i < lim && bus_resp !== want; i++) tick(1);
    endtask
    task automatic wait_rst();
        for (int i = 0; i < 20 && sys_rst_n !== 1'h1; i++) tick(1);
    endtask
    ////////////////////////////////////////
    task automatic t_power();
        chk1("sys_rst_n", 1'h0, sys_rst_n);
        chk4("bus_resp", 4'h9, bus_resp);
        chk1("dgrant", 1'h1, dgrant);
        chk4("dtrans", 4'h0, {2'h0, dtrans});
        chk4("pos", 4'he, pos);
        reset_n = 1'h1;
        tick(12);
        chk1("sys_rst_n", 1'h0, sys_rst_n);
        cfg = 1'h1;
        tick(1);
        chk1("sys_rst_n", 1'h0, sys_rst_n);
        wait_rst();
        chk1("sys_rst_n", 1'h1, sys_rst_n);
        tick(4);
        chk4("bus_grant", 4'h8, bus_grant);
        chk1("dgrant", 1'h0, dgrant);
    endtask
    // Back-to-back transfers to an unused address; the first is checked for the two-cycle error.
    task automatic t_error();
        nxt_trans = `SSBC_TRANS_NONSEQ;
        wait_resp(4'h3, 20);
        chk4("bus_resp", 4'h3, bus_resp);
        wait_resp(4'hb, 3);
        chk4("bus_resp", 4'hb, bus_resp);
    endtask
    // Window edges inside and a real tile slave must leave the drive off; the edges just outside must see it.
    task automatic t_decode();
        logic [31:0] adr [6];
        logic [1:0]  flg [6];
        logic        seen;
        adr = '{32'h80000000, 32'ha0000000, 32'hbffffffc, 32'h7ffffffc, 32'hc0000000,
                32'h10000000};
        flg = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
        for (int i = 0; i < 6; i++) begin
            nxt_addr = adr[i];
            hit = flg[i][1];
            tick(8);
            seen = 1'h0;
            repeat (8) begin
                tick(1);
                seen = seen | bus_resp.oe;
            end
            chk1("drive", flg[i][0], seen);
        end
        nxt_trans = `SSBC_TRANS_IDLE;
        nxt_addr = 32'h0;
        hit = 1'h0;
    endtask
    // Each word is request, lock, then the grant expected.
    task automatic t_grant();
        logic [11:0] tb [7];
        tb = '{12'h101, 12'h008, 12'h408, 12'h908, 12'h111, 12'h911, 12'h908};
        for (int i = 0; i < 7; i++) begin
            {bus_request, bus_lock} = tb[i][11:4];
            tick(4);
            chk4("bus_grant", tb[i][3:0], bus_grant);
            chk4("tm_oe", {1'h0, tb[i][2:0]}, {1'h0, tm_oe});
        end
    endtask
    // A local source, then the debug probe, pull the wired line.
    task automatic t_resets();
        for (int s = 0; s < 2; s++) begin
            tile_req = (s == 0);
            probe = (s == 1);
            tick(1);
            chk1("rq_oe", s == 0, rq_oe);
            chk1("rq_o", 1'h0, rq_o);
            chk1("sys_rst_n", 1'h0, sys_rst_n);
            tick(4);
            chk1("dgrant", 1'h1, dgrant);
            tile_req = 1'h0;
            probe = 1'h0;
            tick(1);
            chk1("sys_rst_n", 1'h0, sys_rst_n);
            wait_rst();
            chk1("sys_rst_n", 1'h1, sys_rst_n);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        reset_n = 1'h0;
        tile_req = 1'h0;
        probe = 1'h0;
        cfg = 1'h0;
        hit = 1'h0;
        nxt_addr = 32'h0;
        nxt_trans = `SSBC_TRANS_IDLE;
        bus_request = 4'h0;
        bus_lock = 4'h0;
        err_count = 0;
        n_checks = 0;
        tick(16);
        t_power();
        t_error();
        t_decode();
        t_grant();
        t_resets();
        final_report();
    end
endmodule
`default_nettype wire
